// >>> shared/dic_pkg.sv
// Purpose: Constants for the digital input conditioner.
// Assumes: 100 MHz clock, 32-bit register port with byte addresses.
// Notes: Offsets are byte addresses of aligned words.
package dic_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FAST_FILT = 8'h04;
  localparam logic [7:0] OFS_STD_FILT = 8'h08;
  localparam logic [7:0] OFS_FMIN = 8'h0c;
  localparam logic [7:0] OFS_FMAX = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_FREQ = 8'h18;
  localparam logic [7:0] OFS_PERCENT = 8'h1c;
  localparam logic [7:0] OFS_INT_STS = 8'h20;
  localparam logic [7:0] OFS_INT_MASK = 8'h24;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INV_BIT = 3;
  localparam int CTRL_REACT_BIT = 4;
  localparam int CTRL_TRIG_LSB = 5;
  localparam logic [2:0] MODE_INACTIVE = 3'h0;
  localparam logic [2:0] MODE_BOOL = 3'h3;
  localparam logic [2:0] MODE_PULSE = 3'h4;
  localparam logic [1:0] TRIG_NONE = 2'h0;
  localparam logic [1:0] TRIG_RISE = 2'h1;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;
  localparam logic [6:0] FAST_FILT_RST = 7'h00;
  localparam logic [6:0] STD_FILT_RST = 7'h05;
  localparam logic [16:0] FMIN_RST = 17'h00000;
  localparam logic [16:0] FMAX_RST = 17'h1adb0;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam int INT_TRIG_BIT = 0;
  localparam int INT_MEAS_BIT = 1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TICK_NS = 1000000;
  localparam int FAST_TICK_NS = 500;
  localparam int GATE_NS = 1000000000;
  localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam int FAST_TICK_CYCLES = FAST_TICK_NS / CLK_PERIOD_NS;
  localparam int GATE_CYCLES = GATE_NS / CLK_PERIOD_NS;
  typedef enum logic [0:0] {DIC_IDLE, DIC_DIV} dic_div_t;
endpackage

// >>> design/dic_top.sv
// Purpose: Conditions one digital input terminal of a motor drive.
// Assumes: One 100 MHz clock; pin is asynchronous to it.
// Notes: Instantiate once per terminal (input_terminal_a, _b).
`timescale 1ns/10ps
// Functional notes
// RULE1: Mode 0 inactive, 3 boolean, 4 pulse input; boolean after reset.
// RULE2: Pulse mode measures input frequency as an analog value.
// RULE3: Inversion 0 passes, 1 inverts the signal; resets to 0.
// RULE4: Fast filter time 0 to 63.50 us in 0.5 us steps; resets 0.
// RULE5: Standard filter time 0 to 127 ms in 1 ms steps; resets 5.
// RULE6: Filter ticks every 1 ms when reaction is 0, every 0.5 us if 1.
// RULE7: Standard reaction handles the input like any other input.
// RULE8: Fast reaction gives a fast event path at the 0.5 us tick.
// RULE9: Trigger 0 none, 1 rising, 2 falling, 3 both edges; resets 0.
// RULE10: Minimum frequency 0 to 110000 Hz maps to 0 percent; resets 0.
// RULE11: Maximum frequency maps to 100 percent; resets to 110000 Hz.
// RULE12: Invert first, then debounce, then detect edges.
// RULE13: Percent is linear between min and max, clamped to 0..100.
module dic_top
  import dic_pkg::*;
#(
  parameter int MS_CYCLES = dic_pkg::MS_TICK_CYCLES,
  parameter int GATE_LEN = dic_pkg::GATE_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic input_terminal,
  input wire logic [dic_pkg::ADDR_W-1:0] addr,
  input wire logic [dic_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [dic_pkg::DATA_W-1:0] rd_data,
  output logic level_out,
  output logic trigger_event,
  output logic fast_event,
  output logic irq
);
  import dic_pkg::*;

  // ----------------------------------------------------------------
  // Configuration and interrupt registers
  // ----------------------------------------------------------------
  logic [2:0] mode_r, mode_nxt;
  logic inv_r, inv_nxt;
  logic react_r, react_nxt;
  logic [1:0] trig_r, trig_nxt;
  logic [6:0] fast_filt_r, fast_filt_nxt;
  logic [6:0] std_filt_r, std_filt_nxt;
  logic [16:0] fmin_r, fmin_nxt;
  logic [16:0] fmax_r, fmax_nxt;
  logic [1:0] int_sts_r, int_sts_nxt;
  logic [1:0] int_mask_r, int_mask_nxt;
  logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
  logic [1:0] int_set;
  logic [16:0] freq_r;
  logic [6:0] pct_r;
  logic filt_r;

  function automatic logic [16:0] sat17(input logic [31:0] v);
    sat17 = (v > 32'(FMAX_RST)) ? FMAX_RST : v[16:0];
  endfunction

  always_comb
  begin
    mode_nxt = mode_r;
    inv_nxt = inv_r;
    react_nxt = react_r;
    trig_nxt = trig_r;
    fast_filt_nxt = fast_filt_r;
    std_filt_nxt = std_filt_r;
    fmin_nxt = fmin_r;
    fmax_nxt = fmax_r;
    int_mask_nxt = int_mask_r;
    int_sts_nxt = int_sts_r;
    rd_data_nxt = '0;
    if (wr_en)
    begin
      case (addr)
        OFS_CTRL:
        begin
          mode_nxt = wr_data[CTRL_MODE_LSB +: 3]; // [RULE1]
          inv_nxt = wr_data[CTRL_INV_BIT]; // [RULE3]
          react_nxt = wr_data[CTRL_REACT_BIT]; // [RULE6]
          trig_nxt = wr_data[CTRL_TRIG_LSB +: 2]; // [RULE9]
        end
        OFS_FAST_FILT: fast_filt_nxt = wr_data[6:0]; // [RULE4]
        OFS_STD_FILT: std_filt_nxt = wr_data[6:0]; // [RULE5]
        OFS_FMIN: fmin_nxt = sat17(wr_data); // [RULE10]
        OFS_FMAX: fmax_nxt = sat17(wr_data); // [RULE11]
        OFS_INT_STS: int_sts_nxt = int_sts_r & ~wr_data[1:0];
        OFS_INT_MASK: int_mask_nxt = wr_data[1:0];
        default: mode_nxt = mode_r;
      endcase
    end
    int_sts_nxt = int_sts_nxt | int_set;
    if (rd_en)
    begin
      case (addr)
        OFS_CTRL: rd_data_nxt = {25'h0, trig_r, react_r, inv_r, mode_r};
        OFS_FAST_FILT: rd_data_nxt = {25'h0, fast_filt_r};
        OFS_STD_FILT: rd_data_nxt = {25'h0, std_filt_r};
        OFS_FMIN: rd_data_nxt = {15'h0, fmin_r};
        OFS_FMAX: rd_data_nxt = {15'h0, fmax_r};
        OFS_STATUS: rd_data_nxt = {30'h0, react_r, filt_r};
        OFS_FREQ: rd_data_nxt = {15'h0, freq_r};
        OFS_PERCENT: rd_data_nxt = {25'h0, pct_r};
        OFS_INT_STS: rd_data_nxt = {30'h0, int_sts_r};
        OFS_INT_MASK: rd_data_nxt = {30'h0, int_mask_r};
        default: rd_data_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= MODE_BOOL; // [RULE1]
      inv_r <= 1'b0; // [RULE3]
      react_r <= 1'b0; // [RULE6]
      trig_r <= TRIG_NONE; // [RULE9]
      fast_filt_r <= FAST_FILT_RST; // [RULE4]
      std_filt_r <= STD_FILT_RST; // [RULE5]
      fmin_r <= FMIN_RST; // [RULE10]
      fmax_r <= FMAX_RST; // [RULE11]
      int_sts_r <= 2'h0;
      int_mask_r <= 2'h0;
      rd_data_r <= '0;
    end
    else
    begin
      mode_r <= mode_nxt;
      inv_r <= inv_nxt;
      react_r <= react_nxt;
      trig_r <= trig_nxt;
      fast_filt_r <= fast_filt_nxt;
      std_filt_r <= std_filt_nxt;
      fmin_r <= fmin_nxt;
      fmax_r <= fmax_nxt;
      int_sts_r <= int_sts_nxt;
      int_mask_r <= int_mask_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign irq = |(int_sts_r & int_mask_r);

  // ----------------------------------------------------------------
  // Input path: synchroniser, ticks, debounce, edges
  // ----------------------------------------------------------------
  logic sync1_r, sync2_r;
  logic [31:0] ms_cnt_r, ms_cnt_nxt;
  logic [7:0] fast_cnt_r, fast_cnt_nxt;
  logic [6:0] db_cnt_r, db_cnt_nxt;
  logic filt_nxt, filt_d_r, level_r, level_nxt;
  logic trig_ev_r, trig_ev_nxt, fast_ev_r, fast_ev_nxt;
  logic ms_tick, fast_tick, tick, sig, active, rise, fall, edge_hit;
  logic [6:0] limit;

  always_comb
  begin
    active = (mode_r == MODE_BOOL) || (mode_r == MODE_PULSE); // [RULE1]
    ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
    fast_tick = (fast_cnt_r == 8'(FAST_TICK_CYCLES - 1));
    ms_cnt_nxt = ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
    fast_cnt_nxt = fast_tick ? 8'h0 : fast_cnt_r + 8'h1;
    tick = react_r ? fast_tick : ms_tick; // [RULE6]
    limit = react_r ? fast_filt_r : std_filt_r;
    sig = sync2_r ^ inv_r; // [RULE3] [RULE12]
    filt_nxt = filt_r;
    db_cnt_nxt = db_cnt_r;
    if (!active)
    begin
      filt_nxt = 1'b0;
      db_cnt_nxt = 7'h0;
    end
    else if (sig == filt_r)
      db_cnt_nxt = 7'h0;
    else if (limit == 7'h0)
      filt_nxt = sig; // [RULE12]
    else if (tick)
    begin
      if (db_cnt_r + 7'h1 >= limit)
      begin
        filt_nxt = sig; // [RULE12]
        db_cnt_nxt = 7'h0;
      end
      else
        db_cnt_nxt = db_cnt_r + 7'h1;
    end
    rise = filt_r & ~filt_d_r;
    fall = ~filt_r & filt_d_r;
    case (trig_r) // [RULE9]
      TRIG_RISE: edge_hit = rise;
      TRIG_FALL: edge_hit = fall;
      TRIG_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
    trig_ev_nxt = edge_hit & active; // [RULE12] [RULE7]
    fast_ev_nxt = edge_hit & active & react_r; // [RULE8]
    level_nxt = filt_r & (mode_r == MODE_BOOL);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      ms_cnt_r <= 32'h0;
      fast_cnt_r <= 8'h0;
      db_cnt_r <= 7'h0;
      filt_r <= 1'b0;
      filt_d_r <= 1'b0;
      level_r <= 1'b0;
      trig_ev_r <= 1'b0;
      fast_ev_r <= 1'b0;
    end
    else
    begin
      sync1_r <= input_terminal;
      sync2_r <= sync1_r;
      ms_cnt_r <= ms_cnt_nxt;
      fast_cnt_r <= fast_cnt_nxt;
      db_cnt_r <= db_cnt_nxt;
      filt_r <= filt_nxt;
      filt_d_r <= filt_r;
      level_r <= level_nxt;
      trig_ev_r <= trig_ev_nxt;
      fast_ev_r <= fast_ev_nxt;
    end
  end

  assign level_out = level_r;
  assign trigger_event = trig_ev_r;
  assign fast_event = fast_ev_r;

  // ----------------------------------------------------------------
  // Pulse frequency measurement and scaling
  // ----------------------------------------------------------------
  dic_div_t st_r, st_nxt;
  logic [31:0] gate_r, gate_nxt;
  logic [16:0] edges_r, edges_nxt, freq_nxt;
  logic [23:0] rem_r, rem_nxt, den_r, den_nxt;
  logic [6:0] q_r, q_nxt, pct_nxt;
  logic gate_end, pulse;

  always_comb
  begin
    pulse = (mode_r == MODE_PULSE);
    gate_end = (gate_r == 32'(GATE_LEN - 1));
    gate_nxt = (gate_end || !pulse) ? 32'h0 : gate_r + 32'h1;
    edges_nxt = edges_r;
    freq_nxt = freq_r;
    st_nxt = st_r;
    rem_nxt = rem_r;
    den_nxt = den_r;
    q_nxt = q_r;
    pct_nxt = pct_r;
    int_set = {1'b0, trig_ev_r};
    if (!pulse)
      edges_nxt = 17'h0;
    else if (gate_end)
    begin
      freq_nxt = edges_r; // [RULE2]
      edges_nxt = {16'h0, rise};
      if (fmax_r <= fmin_r || edges_r <= fmin_r || edges_r >= fmax_r)
      begin
        pct_nxt = (edges_r >= fmax_r) ? PCT_FULL : 7'h0; // [RULE13]
        int_set[INT_MEAS_BIT] = 1'b1;
      end
      else
      begin
        rem_nxt = 24'(edges_r - fmin_r) * 24'(PCT_FULL); // [RULE13]
        den_nxt = 24'(fmax_r - fmin_r);
        q_nxt = 7'h0;
        st_nxt = DIC_DIV;
      end
    end
    else if (rise && edges_r != FMAX_RST)
      edges_nxt = edges_r + 17'h1; // [RULE2]
    case (st_r)
      DIC_IDLE: q_nxt = q_nxt;
      DIC_DIV:
      begin
        if (rem_r >= den_r)
        begin
          rem_nxt = rem_r - den_r;
          q_nxt = q_r + 7'h1;
        end
        else
        begin
          pct_nxt = q_r; // [RULE13]
          int_set[INT_MEAS_BIT] = 1'b1;
          st_nxt = DIC_IDLE;
        end
      end
      default: st_nxt = DIC_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= DIC_IDLE;
      gate_r <= 32'h0;
      edges_r <= 17'h0;
      freq_r <= 17'h0;
      rem_r <= 24'h0;
      den_r <= 24'h0;
      q_r <= 7'h0;
      pct_r <= 7'h0;
    end
    else
    begin
      st_r <= st_nxt;
      gate_r <= gate_nxt;
      edges_r <= edges_nxt;
      freq_r <= freq_nxt;
      rem_r <= rem_nxt;
      den_r <= den_nxt;
      q_r <= q_nxt;
      pct_r <= pct_nxt;
    end
  end
endmodule

// >>> verification/dic_src.sv
// Purpose: Field source driving the input pin.
// Assumes: Bench gives a level or a half period.
// Notes: Half period 0 gives a static level.
`timescale 1ns/10ps
module dic_src
(
  input wire logic clock,
  input wire logic level,
  input wire logic [7:0] half,
  output logic pin
);
  // ----------------
  // Source
  // ----------------
  logic pin_r = 1'b0;
  logic [7:0] cnt_r = 8'h00;
  assign pin = pin_r;
  always_ff @(posedge clock)
  begin
    if (half == 8'h00)
    begin
      pin_r <= level;
      cnt_r <= 8'h00;
    end
    else if (cnt_r + 8'h01 >= half)
    begin
      pin_r <= ~pin_r;
      cnt_r <= 8'h00;
    end
    else
      cnt_r <= cnt_r + 8'h01;
  end
endmodule

// >>> verification/dic_top_chk.sv
// Purpose: Port checks for the input conditioner.
// Assumes: One clock, CTRL mirrored from bus writes.
// Notes: Steady means no CTRL write for five cycles.
`timescale 1ns/10ps
module dic_chk
  import dic_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic input_terminal,
  input wire logic [dic_pkg::ADDR_W-1:0] addr,
  input wire logic [dic_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [dic_pkg::DATA_W-1:0] rd_data,
  input wire logic level_out,
  input wire logic trigger_event,
  input wire logic fast_event,
  input wire logic irq
);
  // ----------------
  // Checks
  // ----------------
  logic [6:0] ctl_r;
  logic [6:0] ctl_nxt;
  logic [2:0] age_r;
  logic [2:0] age_nxt;
  logic st;
  always_comb
  begin
    ctl_nxt = ctl_r;
    age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
    if (wr_en && addr == OFS_CTRL)
    begin
      ctl_nxt = wr_data[6:0];
      age_nxt = 3'h0;
    end
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r <= 7'h03;
      age_r <= 3'h7;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      age_r <= age_nxt;
    end
  end
  assign st = age_r > 3'h4;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_read_idle: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data outside read slot");
  a_idle_quiet: assert property (st && ctl_r[2:0] == MODE_INACTIVE
    |-> !trigger_event && !level_out) else $error("inactive pin active");
  a_pulse_nolvl: assert property (st && ctl_r[2:0] == MODE_PULSE
    |-> !level_out) else $error("level in pulse mode");
  a_fast_subset: assert property (fast_event |-> trigger_event)
    else $error("fast event alone");
  a_std_nofast: assert property (st && !ctl_r[4] |-> !fast_event)
    else $error("fast event in standard mode");
  a_fast_path: assert property (st && ctl_r[4] && trigger_event
    |-> fast_event) else $error("fast event missing");
  a_trig_none: assert property (st && ctl_r[6:5] == TRIG_NONE
    |-> !trigger_event) else $error("event with trigger off");
  a_rise_level: assert property (st && ctl_r == {TRIG_RISE, 2'h0, 3'h3}
    && trigger_event |-> level_out) else $error("rise event low");
  a_fall_level: assert property (st && ctl_r[6:5] == TRIG_FALL
    && trigger_event |-> !level_out) else $error("fall event high");
  a_level_event: assert property (st && ctl_r[6:5] == TRIG_BOTH
    && ctl_r[2:0] == MODE_BOOL && $changed(level_out) |-> trigger_event)
    else $error("level change without event");
  c_trig: cover property (trigger_event);
  c_fast: cover property (fast_event);
  c_irq: cover property (irq);
endmodule
bind dic_top dic_chk dic_chk_inst (.clock(clock), .rst_n(rst_n),
  .input_terminal(input_terminal), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .level_out(level_out),
  .trigger_event(trigger_event), .fast_event(fast_event), .irq(irq));

// >>> verification/dic_top_bench.sv
// Purpose: Self-checking bench for the input conditioner.
// Assumes: Short tick of 20 cycles and gate of 200 cycles.
// Notes: Events are counted at the falling edge.
`timescale 1ns/10ps
module dic_top_bench;
  import dic_pkg::*;
  // ----------------
  // Bench
  // ----------------
  logic clock = 1'b0, rst_n = 1'b0, pin, lvl = 1'b0;
  logic wr_en = 1'b0, rd_en = 1'b0, level_out, trigger_event;
  logic fast_event, irq;
  logic [7:0] addr = 8'h00, half = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data, v, p;
  int fails = 0, comparisons = 0, nt = 0, nf = 0, h, fe;
  int lo_t[3] = '{0, 10, 30};
  int hi_t[3] = '{10, 30, 60};
  always #5 clock = ~clock;
  always @(negedge clock)
  begin
    nt += (trigger_event === 1'b1);
    nf += (fast_event === 1'b1);
  end
  dic_src dic_src_inst (.clock(clock), .level(lvl), .half(half), .pin(pin));
  dic_top #(.MS_CYCLES(20), .GATE_LEN(200)) dic_top_inst (.clock(clock),
    .rst_n(rst_n), .input_terminal(pin), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .level_out(level_out),
    .trigger_event(trigger_event), .fast_event(fast_event), .irq(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(posedge clock);
    d = rd_data;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk("register", e, v);
  endtask
  function automatic int pct(int f, int lo, int hi);
    if (hi <= lo)
      return (f >= hi) ? 100 : 0;
    if (f <= lo)
      return 0;
    return (f >= hi) ? 100 : (f - lo) * 100 / (hi - lo);
  endfunction
  task automatic bounce(input logic [31:0] c, input logic [7:0] a, int t);
    lvl <= 1'b0;
    wr(OFS_CTRL, c);
    wr(a, 32'h3);
    repeat (5 * t) @(posedge clock);
    nt = 0;
    lvl <= 1'b1;
    repeat (t) @(posedge clock);
    lvl <= 1'b0;
    repeat (5 * t) @(posedge clock);
    chk("glitch", 0, nt);
    lvl <= 1'b1;
    repeat (2 * t - 5) @(posedge clock);
    chk("early", 0, level_out);
    repeat (3 * t + 5) @(posedge clock);
    chk("held", 1, level_out);
    chk("events", 1, nt);
    rchk(OFS_STATUS, {30'h0, c[4], 1'b1});
  endtask
  task automatic waitirq();
    wr(OFS_INT_STS, 32'h2);
    for (int w = 0; w < 400 && irq !== 1'b1; w++)
      @(posedge clock);
    chk("irq", 1, irq);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #500000;
    fails++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'hbaf1));
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rchk(OFS_CTRL, 32'h3);
    rchk(OFS_FAST_FILT, 32'h0);
    rchk(OFS_STD_FILT, 32'h5);
    rchk(OFS_FMIN, 32'h0);
    rchk(8'h30, 32'h0);
    rchk(OFS_FMAX, 32'h1adb0);
    wr(OFS_FMAX, 32'h1ffff);
    rchk(OFS_FMAX, 32'h1adb0);
    wr(OFS_STD_FILT, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      wr(OFS_CTRL, {25'h0, k[1:0], k[2], k[2], MODE_BOOL});
      repeat (8) @(posedge clock);
      nt = 0;
      nf = 0;
      lvl <= 1'b1;
      repeat (8) @(posedge clock);
      chk("level", {31'h0, !k[2]}, level_out);
      lvl <= 1'b0;
      repeat (8) @(posedge clock);
      chk("trig", k[0] + k[1], nt);
      chk("fast", k[2] ? k[0] + k[1] : 0, nf);
    end
    wr(OFS_CTRL, 32'h60);
    nt = 0;
    lvl <= 1'b1;
    repeat (8) @(posedge clock);
    chk("idle", 0, level_out | nt);
    bounce({25'h0, TRIG_RISE, 2'h0, MODE_BOOL}, OFS_STD_FILT, 20);
    bounce({25'h0, TRIG_RISE, 2'h2, MODE_BOOL}, OFS_FAST_FILT, 50);
    wr(OFS_INT_MASK, 32'h2);
    // Pulses are shorter than one tick, so the filter must be off here.
    wr(OFS_STD_FILT, 32'h0);
    for (int j = 0; j < 3; j++)
    begin
      h = 4 + $urandom % 4;
      fe = 100 / h;
      wr(OFS_FMIN, lo_t[j]);
      wr(OFS_FMAX, hi_t[j]);
      wr(OFS_CTRL, {25'h0, 4'h0, MODE_PULSE});
      half <= 8'(h);
      waitirq();
      waitirq();
      rd(OFS_FREQ, v);
      rd(OFS_PERCENT, p);
      chk("freq", 1, v + 1 >= fe && v <= fe + 1);
      chk("pct", 1, p >= pct(fe - 1, lo_t[j], hi_t[j])
        && p <= pct(fe + 1, lo_t[j], hi_t[j]));
    end
    // Stop measuring and let a running division finish before W1C tests.
    wr(OFS_CTRL, 32'h0);
    repeat (120) @(posedge clock);
    rchk(OFS_INT_STS, 32'h3);
    wr(OFS_INT_MASK, 32'h0);
    chk("masked", 0, irq);
    wr(OFS_INT_MASK, 32'h2);
    chk("unmasked", 1, irq);
    wr(OFS_INT_STS, 32'h3);
    chk("cleared", 0, irq);
    rchk(OFS_INT_STS, 32'h0);
    print_verdict();
  end
endmodule
